// ==== pipe_ready_pkg.sv ====
// Constants, register map and event carrier for the pipe buffer-ready block
package pipe_ready_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_MASK = 6'h08;
  localparam logic [5:0] OFF_SUMMARY = 6'h0c;
  localparam logic [5:0] OFF_XFEREND = 6'h10;
  localparam logic [5:0] OFF_CONT = 6'h14;
  localparam logic [5:0] OFF_ISO = 6'h18;
  localparam logic [5:0] OFF_TCOUNT = 6'h1c;
  localparam logic [5:0] OFF_BUFSTATE = 6'h20;
  localparam logic [5:0] OFF_BUFCLR = 6'h24;
  // Control register fields
  localparam int CTRL_ROLE_BIT = 0;
  localparam int CTRL_CLRMODE_BIT = 1;
  // Pipe 0 never takes the transfer-end option
  localparam logic [15:0] XFEREND_ALLOWED = 16'hfffe;
  // AXI answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [7:0] TCOUNT_RESET = 8'h01;

  // One end-of-packet report from the USB packet engine
  typedef struct packed {
    logic valid;      // One-cycle pulse
    logic send;       // 1 = data sent, 0 = data received
    logic acked;      // Handshake phase completed
    logic [3:0] pipe;
    logic shortPkt;   // Short packet received
    logic zeroLen;    // Zero-length packet received
    logic bufFull;    // Buffer filled by this packet
  } pkt_evt_t;
endpackage : pipe_ready_pkg

// ==== pipe_buffer_ready_event.sv ====
// Per-pipe buffer-ready event generator with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module pipe_buffer_ready_event #(
  parameter int NPIPES = 10,
  parameter int TCW = 8
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Packet engine and DMA side
  input wire pipe_ready_pkg::pkt_evt_t pktEvt,
  input wire logic [NPIPES-1:0] dmaXferEnd,
  input wire logic [NPIPES-1:0] cpuBufDone,
  // AXI4-Lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt and summary
  output logic buffer_ready_irq,
  output logic readySummary
);
  import pipe_ready_pkg::*;

  // Refuse sizes that the 4-bit pipe field and the one-hot decode cannot serve
  if (NPIPES < 2 || NPIPES > 16)
  begin : badPipes
    $error("NPIPES must be 2..16");
  end
  if (TCW < 1 || TCW > 16)
  begin : badCount
    $error("TCW must be 1..16");
  end

  typedef logic [NPIPES-1:0] pvec_t;

  // One-hot decode of a pipe number, zero when out of range
  function automatic pvec_t pipeOh(input logic [3:0] p);
    pvec_t v;
    v = '0;
    for (int i = 0; i < NPIPES; i++) v[i] = (p == 4'(i));
    return v;
  endfunction : pipeOh

  // Merge write data into a register by byte strobes
  function automatic logic [31:0] strbMask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strbMask

  // Register state
  logic roleHost;
  logic ready_clear_mode;
  pvec_t buffer_ready_status;
  pvec_t irqMask;
  pvec_t transfer_end_irq_select;
  pvec_t contMode;
  pvec_t isoPipe;
  logic [TCW-1:0] tCount;
  pvec_t buffer_state_flag;
  logic [TCW-1:0] pktCnt [NPIPES];
  logic [5:0] wAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // Bus write decode
  wire doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire [31:0] wMasked = wData & strbMask(wStrb);
  wire [31:0] wKeep = ~strbMask(wStrb);
  wire wCtrl = doWrite & (wAddr == OFF_CTRL);
  wire wStatus = doWrite & (wAddr == OFF_STATUS);
  wire wMask = doWrite & (wAddr == OFF_MASK);
  wire wXfer = doWrite & (wAddr == OFF_XFEREND);
  wire wCont = doWrite & (wAddr == OFF_CONT);
  wire wIso = doWrite & (wAddr == OFF_ISO);
  wire wTcnt = doWrite & (wAddr == OFF_TCOUNT);
  wire wBclr = doWrite & (wAddr == OFF_BUFCLR);
  wire wReadOnly = (wAddr == OFF_SUMMARY) | (wAddr == OFF_BUFSTATE);
  wire wMapped = wCtrl | wStatus | wMask | wXfer | wCont | wIso | wTcnt | wBclr
    | (doWrite & wReadOnly);
  wire pvec_t w1c = wStatus ? wMasked[NPIPES-1:0] : '0;
  wire pvec_t clrReq = wBclr ? wMasked[NPIPES-1:0] : '0;

  // Event qualification; role plays no part, both roles raise it
  wire pvec_t evtOh = pipeOh(pktEvt.pipe) & {NPIPES{pktEvt.valid & ce}};
  wire pvec_t evtDone = evtOh & (isoPipe | {NPIPES{pktEvt.acked}});
  wire pvec_t rxHit = pktEvt.send ? '0 : evtDone;
  wire pvec_t txHit = pktEvt.send ? evtDone : '0;
  wire pvec_t xferSel = transfer_end_irq_select & XFEREND_ALLOWED[NPIPES-1:0];
  wire rxEnd = pktEvt.shortPkt | pktEvt.zeroLen | pktEvt.bufFull;
  pvec_t cntHit;
  always_comb
  begin
    for (int i = 0; i < NPIPES; i++) cntHit[i] = (pktCnt[i] + TCW'(1)) == tCount;
  end
  // Continuous pipes wait for short, zero-length, full or count; others go every packet
  wire pvec_t readCond = ~contMode | {NPIPES{rxEnd}} | cntHit;
  // Unread data blocks handing the buffer to the CPU
  wire pvec_t makeReadable = rxHit & readCond & ~buffer_state_flag;
  // Ready flag sources; zero-length packets flag like any other
  wire pvec_t setRdy = (makeReadable & ~xferSel)
    | txHit
    | (dmaXferEnd & xferSel & {NPIPES{ce}});
  // Set wins over a same-cycle clear
  wire pvec_t next_status = (buffer_ready_status & ~w1c) | setRdy;
  wire pvec_t next_bufState = (buffer_state_flag & ~(cpuBufDone | clrReq))
    | makeReadable | txHit;
  wire sumClear = ready_clear_mode ? (next_bufState == '0) : (next_status == '0);
  wire next_summary = (|setRdy) | (readySummary & ~sumClear);

  // Read mux
  logic [31:0] rdMux;
  logic rdOk;
  always_comb
  begin
    rdMux = READ_ZERO;
    rdOk = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL:
      begin
        rdMux[CTRL_ROLE_BIT] = roleHost;
        rdMux[CTRL_CLRMODE_BIT] = ready_clear_mode;
      end
      OFF_STATUS: rdMux[NPIPES-1:0] = buffer_ready_status;
      OFF_MASK: rdMux[NPIPES-1:0] = irqMask;
      OFF_SUMMARY: rdMux[0] = readySummary;
      OFF_XFEREND: rdMux[NPIPES-1:0] = xferSel;
      OFF_CONT: rdMux[NPIPES-1:0] = contMode;
      OFF_ISO: rdMux[NPIPES-1:0] = isoPipe;
      OFF_TCOUNT: rdMux[TCW-1:0] = tCount;
      OFF_BUFSTATE: rdMux[NPIPES-1:0] = buffer_state_flag;
      OFF_BUFCLR: rdMux = READ_ZERO;
      default: rdOk = 1'b0;
    endcase
  end

  // AXI write channels: address and data taken in either order
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awready & s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        wAddr <= s_axi_awaddr;
      end
      if (s_axi_wready & s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI read channel: one cycle to the answer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= READ_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arready & s_axi_arvalid)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      roleHost <= 1'b0;
      ready_clear_mode <= 1'b0;
      irqMask <= '0;
      transfer_end_irq_select <= '0;
      contMode <= '0;
      isoPipe <= '0;
      tCount <= TCW'(TCOUNT_RESET);
    end
    else if (ce)
    begin
      if (wCtrl & wStrb[0])
      begin
        roleHost <= wData[CTRL_ROLE_BIT];
        ready_clear_mode <= wData[CTRL_CLRMODE_BIT];
      end
      if (wMask) irqMask <= (irqMask & wKeep[NPIPES-1:0]) | wMasked[NPIPES-1:0];
      if (wXfer)
        transfer_end_irq_select <= (transfer_end_irq_select & wKeep[NPIPES-1:0])
          | wMasked[NPIPES-1:0];
      if (wCont) contMode <= (contMode & wKeep[NPIPES-1:0]) | wMasked[NPIPES-1:0];
      if (wIso) isoPipe <= (isoPipe & wKeep[NPIPES-1:0]) | wMasked[NPIPES-1:0];
      if (wTcnt) tCount <= (tCount & wKeep[TCW-1:0]) | wMasked[TCW-1:0];
    end
  end

  // Ready flags, buffer states, summary and interrupt line
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      buffer_ready_status <= '0;
      buffer_state_flag <= '0;
      readySummary <= 1'b0;
      buffer_ready_irq <= 1'b0;
    end
    else if (ce)
    begin
      buffer_ready_status <= next_status;
      buffer_state_flag <= next_bufState;
      readySummary <= next_summary;
      buffer_ready_irq <= |(next_status & irqMask);
    end
  end

  // Packets received toward the transaction count; reset when handed over
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NPIPES; i++)
    begin
      if (sys_rst) pktCnt[i] <= '0;
      else if (ce & (makeReadable[i] | clrReq[i])) pktCnt[i] <= '0;
      else if (ce & rxHit[i]) pktCnt[i] <= pktCnt[i] + TCW'(1);
    end
  end

  // Checks
  a_irq_follows_mask: assert property (@(posedge mclk) disable iff (sys_rst)
    ce |=> buffer_ready_irq == |($past(next_status) & $past(irqMask)))
    else $error("interrupt line does not follow masked status");
  a_set_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && setRdy != '0 |=> readySummary && ((buffer_ready_status & $past(setRdy)) != '0))
    else $error("ready set lost");
  a_zlp_flags: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && pktEvt.valid && !pktEvt.send && pktEvt.zeroLen && (makeReadable & ~xferSel) != '0
    |=> (buffer_ready_status & $past(evtOh)) != '0)
    else $error("zero-length packet did not flag");
  a_xfer_end_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && (makeReadable & xferSel & ~buffer_ready_status & ~dmaXferEnd) != '0
    |=> (buffer_ready_status & $past(makeReadable) & $past(xferSel)
      & ~$past(buffer_ready_status) & ~$past(dmaXferEnd)) == '0)
    else $error("flag raised on readable with transfer-end option");
  a_pipe0_no_xfer: assert property (@(posedge mclk) disable iff (sys_rst)
    xferSel[0] == 1'b0)
    else $error("pipe 0 took the transfer-end option");
  a_unread_blocks: assert property (@(posedge mclk) disable iff (sys_rst)
    (makeReadable & buffer_state_flag) == '0)
    else $error("buffer handed over while unread data remained");
  a_tx_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && txHit != '0 |=> (buffer_ready_status & buffer_state_flag & $past(txHit)) != '0)
    else $error("acknowledged send did not flag");
  a_no_ack_no_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && pktEvt.valid && !pktEvt.acked && (evtOh & isoPipe) == '0 |-> evtDone == '0)
    else $error("non-isochronous packet taken without acknowledge");
  a_summary_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && !ready_clear_mode && setRdy == '0 && next_status == '0 |=> !readySummary)
    else $error("summary not cleared in mode 0");
  a_bresp_after: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
endmodule : pipe_buffer_ready_event

// ==== usb_engine_model.sv ====
// Packet engine and DMA stand-in that drives the block's event inputs
`timescale 1ns/1ps
module usb_engine_model #(
  parameter int NPIPES = 10
) (
  // Clock
  input wire logic mclk,
  // Event pulses toward the block
  output pipe_ready_pkg::pkt_evt_t pktEvt,
  output logic [NPIPES-1:0] dmaXferEnd,
  output logic [NPIPES-1:0] cpuBufDone
);
  import pipe_ready_pkg::*;
  // Quiet lines from time zero so the block never sees an unknown event
  initial
  begin
    pktEvt = '0;
    dmaXferEnd = '0;
    cpuBufDone = '0;
  end
  // One packet report as a single-cycle pulse; a real engine never repeats it
  task send(input pkt_evt_t e);
    @(posedge mclk);
    pktEvt <= e;
    @(posedge mclk);
    pktEvt <= '0;
  endtask : send
  // Transfer-end from the DMA or buffer-done from the CPU, one cycle long
  task pulse(input int p, input logic dma);
    @(posedge mclk);
    if (dma)
      dmaXferEnd[p] <= 1'b1;
    else
      cpuBufDone[p] <= 1'b1;
    @(posedge mclk);
    dmaXferEnd <= '0;
    cpuBufDone <= '0;
  endtask : pulse
endmodule : usb_engine_model

// ==== pipe_buffer_ready_event_test.sv ====
// Self-checking bench for the pipe buffer-ready block
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin failCount++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module pipe_buffer_ready_event_test;
  import pipe_ready_pkg::*;
  typedef struct packed {logic role; pkt_evt_t e; logic [9:0] st;} row_t;
  row_t rows [6];
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic ceOn = 1'b1;
  pkt_evt_t pktEvt;
  logic [9:0] dmaXferEnd, cpuBufDone;
  logic [5:0] awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rdData, rData;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic awReady, wReady, bValid, arReady, rValid, irq, summary;
  logic [1:0] bResp, rResp, rdResp;
  int failCount = 0, cmpCount = 0;
  int n;
  // Free-running 125 MHz clock
  always #4 mclk = ~mclk;
  pipe_buffer_ready_event DUT (.mclk(mclk), .sys_rst(sysRst), .ce(ceOn), .pktEvt(pktEvt),
    .dmaXferEnd(dmaXferEnd), .cpuBufDone(cpuBufDone), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .buffer_ready_irq(irq), .readySummary(summary));
  usb_engine_model PE (.mclk(mclk), .pktEvt(pktEvt), .dmaXferEnd(dmaXferEnd),
    .cpuBufDone(cpuBufDone));
  task closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : closeOut
  // A wait that runs out is a mismatch and ends the run
  task hang();
    failCount++;
    closeOut();
  endtask : hang
  // AXI4-Lite write; address and data are released each on its own acceptance
  task wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge mclk);
    awAddr <= a;
    wData <= v;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 40 && !bValid; n++)
    begin
      @(posedge mclk);
      if (awValid && awReady)
        awValid <= 1'b0;
      if (wValid && wReady)
        wValid <= 1'b0;
    end
    bReady <= 1'b0;
    if (n == 40)
      hang();
    `CHK(bResp, RESP_OKAY)
  endtask : wr
  // AXI4-Lite read; data and response taken at the edge that shows rvalid
  task rd(input logic [5:0] a);
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 40 && !rValid; n++)
    begin
      @(posedge mclk);
      if (arValid && arReady)
        arValid <= 1'b0;
    end
    rReady <= 1'b0;
    rdData = rData;
    rdResp = rResp;
    if (n == 40)
      hang();
  endtask : rd
  function automatic pkt_evt_t mk(input logic s, a, input logic [3:0] p, input logic h, z, f);
    return '{1'b1, s, a, p, h, z, f};
  endfunction : mk
  // Event in, then status, interrupt and summary must follow it
  task pktCheck(input pkt_evt_t e, input logic [9:0] s);
    PE.send(e);
    rd(OFF_STATUS);
    `CHK(rdData[9:0], s)
    `CHK(irq, |s)
    `CHK(summary, |s)
  endtask : pktCheck
  // Ready bits are cleared before the buffer, never the other way round
  task clr(input logic [31:0] m);
    wr(OFF_STATUS, m);
    wr(OFF_BUFCLR, m);
  endtask : clr
  initial
  begin
    rows = '{'{1'b0, mk(0, 1, 1, 0, 0, 0), 10'h002}, '{1'b1, mk(0, 1, 2, 0, 1, 0), 10'h004},
      '{1'b0, mk(1, 1, 3, 0, 0, 0), 10'h008}, '{1'b1, mk(0, 0, 4, 0, 0, 0), 10'h000},
      '{1'b0, mk(0, 0, 5, 0, 0, 0), 10'h020}, '{1'b1, mk(0, 1, 12, 0, 0, 0), 10'h000}};
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    rd(OFF_TCOUNT);
    `CHK(rdData, {24'h0, TCOUNT_RESET})
    `CHK(irq, 1'b0)
    wr(OFF_MASK, 32'h3ff);
    wr(OFF_ISO, 32'h20);
    // Ordinary receive, zero-length, send, unacknowledged, isochronous, stray pipe
    foreach (rows[i])
    begin
      wr(OFF_CTRL, {31'h0, rows[i].role});
      pktCheck(rows[i].e, rows[i].st);
      clr(32'h3ff);
      `CHK(summary, 1'b0)
    end
    rd(6'h3c);
    `CHK(rdResp, RESP_SLVERR)
    // Second packet while unread data remains gives no new flag
    PE.send(mk(0, 1, 1, 0, 0, 0));
    wr(OFF_STATUS, 32'h2);
    pktCheck(mk(0, 1, 1, 0, 0, 0), 10'h000);
    clr(32'h2);
    // Masked pipe keeps its status bit but holds the interrupt low
    wr(OFF_MASK, 32'h0);
    PE.send(mk(0, 1, 2, 0, 0, 0));
    rd(OFF_STATUS);
    `CHK(rdData[9:0], 10'h004)
    `CHK(summary, 1'b1)
    `CHK(irq, 1'b0)
    wr(OFF_MASK, 32'h3ff);
    rd(OFF_MASK);
    `CHK(rdData[9:0], 10'h3ff)
    `CHK(irq, 1'b1)
    clr(32'h4);
    // Continuous mode: count reached, short packet, full buffer
    wr(OFF_CONT, 32'h2);
    wr(OFF_TCOUNT, 32'h2);
    pktCheck(mk(0, 1, 1, 0, 0, 0), 10'h000);
    pktCheck(mk(0, 1, 1, 0, 0, 0), 10'h002);
    clr(32'h2);
    pktCheck(mk(0, 1, 1, 1, 0, 0), 10'h002);
    clr(32'h2);
    pktCheck(mk(0, 1, 1, 0, 0, 1), 10'h002);
    clr(32'h2);
    wr(OFF_CONT, 32'h0);
    // Transfer-end option: readable without flag until the DMA finishes
    wr(OFF_XFEREND, 32'h3ff);
    rd(OFF_XFEREND);
    `CHK(rdData[9:0], 10'h3fe)
    pktCheck(mk(0, 1, 1, 0, 0, 0), 10'h000);
    PE.pulse(1, 1'b1);
    rd(OFF_STATUS);
    `CHK(rdData[9:0], 10'h002)
    clr(32'h2);
    wr(OFF_XFEREND, 32'h0);
    // Clear mode 1: summary follows the buffer state, not the status bits
    wr(OFF_CTRL, 32'h2);
    pktCheck(mk(0, 1, 3, 0, 0, 0), 10'h008);
    wr(OFF_STATUS, 32'h8);
    `CHK(summary, 1'b1)
    PE.pulse(3, 1'b0);
    rd(OFF_BUFSTATE);
    `CHK(rdData[9:0], 10'h000)
    `CHK(summary, 1'b0)
    // Reset in mid-run puts every register back, the count to its reset value
    pktCheck(mk(0, 1, 2, 0, 0, 0), 10'h004);
    @(posedge mclk);
    sysRst <= 1'b1;
    repeat (2) @(posedge mclk);
    sysRst <= 1'b0;
    rd(OFF_STATUS);
    `CHK(rdData, READ_ZERO)
    `CHK(irq, 1'b0)
    `CHK(summary, 1'b0)
    rd(OFF_TCOUNT);
    `CHK(rdData, {24'h0, TCOUNT_RESET})
    rd(OFF_CTRL);
    `CHK(rdData, READ_ZERO)
    // A packet report while the clock enable is low leaves no trace
    @(posedge mclk);
    ceOn <= 1'b0;
    PE.send(mk(0, 1, 1, 0, 0, 0));
    ceOn <= 1'b1;
    rd(OFF_STATUS);
    `CHK(rdData, READ_ZERO)
    `CHK(summary, 1'b0)
    closeOut();
  end
endmodule : pipe_buffer_ready_event_test
